// *** common/ela_pkg.sv ***
package ela_pkg;
	// ****************************************
	// host frame layout
	// ****************************************
	localparam int FRAME_W = 48;
	localparam int OP_HI = 47;
	localparam int OP_LO = 44;
	localparam int IDX_HI = 41;
	localparam int IDX_LO = 40;
	localparam int DATA_HI = 39;
	localparam int DATA_W = 40;
	// ****************************************
	// host opcodes
	// ****************************************
	localparam logic [3:0] OP_MASK = 4'h1;
	localparam logic [3:0] OP_MODE0 = 4'h2;
	localparam logic [3:0] OP_MODE1 = 4'h3;
	localparam logic [3:0] OP_COMB = 4'h4;
	localparam logic [3:0] OP_CTRL = 4'h5;
	localparam logic [3:0] OP_STIM = 4'h6;
	localparam logic [3:0] OP_STATUS = 4'h7;
	localparam logic [3:0] OP_READ = 4'h8;
	// ****************************************
	// control word fields
	// ****************************************
	localparam int CTRL_NCOND_LO = 0;
	localparam int CTRL_PRE_LO = 2;
	localparam int CTRL_REP = 4;
	localparam int CTRL_ARM = 5;
	localparam int STAGES = 3;
	// ****************************************
	// reset values
	// ****************************************
	localparam logic [1:0] RST_NCOND_M1 = 2'h0;
	localparam logic [1:0] RST_PRE_Q = 2'h0;
	localparam logic RST_REP = 1'b0;
	localparam int FIFO_DEPTH = 8;
	// ****************************************
	// per-bit match modes {mode1, mode0}
	// ****************************************
	localparam logic [1:0] MATCH_LOW = 2'h0;
	localparam logic [1:0] MATCH_HIGH = 2'h1;
	localparam logic [1:0] MATCH_RISE = 2'h2;
	localparam logic [1:0] MATCH_FALL = 2'h3;
	typedef enum logic [1:0] {
		ELA_IDLE = 2'h0,
		ELA_ARMED = 2'h1,
		ELA_POST = 2'h3,
		ELA_DONE = 2'h2
	} ela_state_t;
endpackage

// *** design/ela_top.sv ***
`timescale 1ns/1ps

// ****************************************
// sample read-out buffer
// ****************************************
module ela_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// fill side
	input wire logic in_valid,
	output logic in_ready,
	input wire logic [W-1:0] in_data,
	// drain side
	output logic out_valid,
	input wire logic out_ready,
	output logic [W-1:0] out_data
);
	localparam int AW = $clog2(D);
	logic [W-1:0] mem [D];
	logic [AW-1:0] wp;
	logic [AW-1:0] rp;
	logic [AW:0] cnt;
	logic push;
	logic pop;

	assign in_ready = cnt != (AW+1)'(D);
	assign out_valid = cnt != '0;
	assign out_data = mem[rp];
	assign push = in_valid && in_ready;
	assign pop = out_valid && out_ready;

	always_ff @(posedge core_clk) begin
		if (push) begin
			mem[wp] <= in_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			wp <= '0;
			rp <= '0;
			cnt <= '0;
		end else begin
			if (push) begin
				wp <= (wp == AW'(D-1)) ? '0 : wp + 1'b1;
			end
			if (pop) begin
				rp <= (rp == AW'(D-1)) ? '0 : rp + 1'b1;
			end
			cnt <= cnt + (AW+1)'(push) - (AW+1)'(pop);
		end
	end
endmodule

// Function
// - the monitor width is a build parameter from 1 to 4064 bits.
// - the capture depth is a build parameter from 512 to 16384 samples, one per clock.
// - the trigger channel is a separate vector of 1 to 40 bits.
// - up to three conditions are met in order and the last configured one fires the capture.
// - each condition selects trigger bits and joins their matches by AND or by OR.
// - each selected bit matches a rising edge, a falling edge or a level.
// - an optional build-time condition is armed straight after reset.
// - the host loads a stimulus vector of 1 to 40 bits that is driven before capture.
// - pre-trigger history is kept in steps of a quarter of the depth.
// - repetitive mode re-arms after each capture has been read out.
// - monitored signals are written every clock from arming to the end of capture into on-chip sample memory.
// - trigger settings arrive over JTAG and samples return over it, whole only for monitor widths up to 47 bits.
// - the JTAG path is shared with user logic and released when not selected.
module ela_top #(
	parameter int MON_W = 8,
	parameter int DEPTH = 512,
	parameter int TRIG_W = 8,
	parameter int STIM_W = 8,
	parameter bit INIT_EN = 1'b0,
	parameter logic [TRIG_W-1:0] INIT_MASK = '0,
	parameter logic [TRIG_W-1:0] INIT_MODE0 = '0,
	parameter logic [TRIG_W-1:0] INIT_MODE1 = '0,
	parameter bit INIT_OR = 1'b0
) (
	// clock and reset
	input wire logic core_clk,
	input wire logic sys_rst,
	// user logic side
	input wire logic [MON_W-1:0] mon_data,
	input wire logic [TRIG_W-1:0] trig_in,
	output logic [STIM_W-1:0] stim_out,
	// shared jtag user chain
	input wire logic jtag_tck,
	input wire logic jtag_tdi,
	input wire logic jtag_sel,
	output logic jtag_tdo,
	output logic jtag_tdo_oe_n,
	// status
	output logic capture_done,
	output logic capture_armed
);
	localparam int AW = $clog2(DEPTH);
	localparam int FW = ela_pkg::FRAME_W;

	// ****************************************
	// link sampling and frame shifter
	// ****************************************
	logic tck_m, tck_s, tck_d;
	logic sel_m, sel_s, sel_d;
	logic tdi_m, tdi_s;
	logic [FW-1:0] shift;
	logic [FW-1:0] next_shift;
	logic [FW-1:0] resp;
	logic tck_rise;
	logic frame_end;
	logic [3:0] op;
	logic [1:0] idx;
	logic [ela_pkg::DATA_W-1:0] pay;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			{tck_m, tck_s, tck_d} <= 3'h0;
			{sel_m, sel_s, sel_d} <= 3'h0;
			{tdi_m, tdi_s} <= 2'h0;
		end else begin
			{tck_m, tck_s, tck_d} <= {jtag_tck, tck_m, tck_s};
			{sel_m, sel_s, sel_d} <= {jtag_sel, sel_m, sel_s};
			{tdi_m, tdi_s} <= {jtag_tdi, tdi_m};
		end
	end

	assign tck_rise = tck_s && !tck_d;
	assign frame_end = sel_d && !sel_s;
	assign op = shift[ela_pkg::OP_HI:ela_pkg::OP_LO];
	assign idx = shift[ela_pkg::IDX_HI:ela_pkg::IDX_LO];
	assign pay = shift[ela_pkg::DATA_HI:0];

	always_comb begin
		next_shift = shift;
		if (frame_end) begin
			next_shift = resp;
		end else if (sel_s && tck_rise) begin
			next_shift = {tdi_s, shift[FW-1:1]};
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			shift <= '0;
			jtag_tdo <= 1'b0;
			jtag_tdo_oe_n <= 1'b1;
		end else begin
			shift <= next_shift;
			jtag_tdo <= next_shift[0];
			// pin is left to the user design whenever our chain is not selected
			jtag_tdo_oe_n <= !sel_s;
		end
	end

	// ****************************************
	// configuration from host frames
	// ****************************************
	logic [TRIG_W-1:0] mask [ela_pkg::STAGES];
	logic [TRIG_W-1:0] mode0 [ela_pkg::STAGES];
	logic [TRIG_W-1:0] mode1 [ela_pkg::STAGES];
	logic [ela_pkg::STAGES-1:0] or_sel;
	logic [1:0] ncond_m1;
	logic [1:0] pre_q;
	logic rep;
	logic cmd_arm;
	logic cmd_write;

	assign cmd_write = frame_end && idx < 2'(ela_pkg::STAGES);
	assign cmd_arm = frame_end && op == ela_pkg::OP_CTRL && pay[ela_pkg::CTRL_ARM];

	generate
		for (genvar c = 0; c < ela_pkg::STAGES; c++) begin : g_cfg
			always_ff @(posedge core_clk) begin
				if (sys_rst) begin
					mask[c] <= (c == 0 && INIT_EN) ? INIT_MASK : '0;
					mode0[c] <= (c == 0 && INIT_EN) ? INIT_MODE0 : '0;
					mode1[c] <= (c == 0 && INIT_EN) ? INIT_MODE1 : '0;
					or_sel[c] <= (c == 0 && INIT_EN) ? INIT_OR : 1'b0;
				end else if (cmd_write && idx == 2'(c)) begin
					if (op == ela_pkg::OP_MASK) begin
						mask[c] <= pay[TRIG_W-1:0];
					end
					if (op == ela_pkg::OP_MODE0) begin
						mode0[c] <= pay[TRIG_W-1:0];
					end
					if (op == ela_pkg::OP_MODE1) begin
						mode1[c] <= pay[TRIG_W-1:0];
					end
					if (op == ela_pkg::OP_COMB) begin
						or_sel[c] <= pay[0];
					end
				end
			end
		end
	endgenerate

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			ncond_m1 <= ela_pkg::RST_NCOND_M1;
			pre_q <= ela_pkg::RST_PRE_Q;
			rep <= ela_pkg::RST_REP;
		end else if (frame_end && op == ela_pkg::OP_CTRL) begin
			ncond_m1 <= pay[ela_pkg::CTRL_NCOND_LO +: 2];
			pre_q <= pay[ela_pkg::CTRL_PRE_LO +: 2];
			rep <= pay[ela_pkg::CTRL_REP];
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			stim_out <= '0;
		end else if (frame_end && op == ela_pkg::OP_STIM) begin
			// loaded by the host ahead of the arm command, so it stands before capture
			stim_out <= pay[STIM_W-1:0];
		end
	end

	// ****************************************
	// trigger evaluation
	// ****************************************
	logic [TRIG_W-1:0] trig_prev;
	logic [ela_pkg::STAGES-1:0] hit;
	logic [1:0] stage;
	logic hit_cur;
	logic trig_fire;

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			trig_prev <= '0;
		end else begin
			trig_prev <= trig_in;
		end
	end

	generate
		for (genvar c = 0; c < ela_pkg::STAGES; c++) begin : g_cond
			logic [TRIG_W-1:0] bit_ok;
			always_comb begin
				for (int b = 0; b < TRIG_W; b++) begin
					case ({mode1[c][b], mode0[c][b]})
						ela_pkg::MATCH_LOW: bit_ok[b] = !trig_in[b];
						ela_pkg::MATCH_HIGH: bit_ok[b] = trig_in[b];
						ela_pkg::MATCH_RISE: bit_ok[b] = trig_in[b] && !trig_prev[b];
						default: bit_ok[b] = !trig_in[b] && trig_prev[b];
					endcase
				end
			end
			// an empty AND selection fires at once; an empty OR selection never does
			assign hit[c] = or_sel[c] ? |(bit_ok & mask[c]) : &(bit_ok | ~mask[c]);
		end
	endgenerate

	assign hit_cur = hit[stage];
	// a count of four conditions is not legal; the third stage is always the last
	assign trig_fire = hit_cur && (stage == ncond_m1 || stage == 2'h2);

	// ****************************************
	// capture sequencer and sample memory
	// ****************************************
	ela_pkg::ela_state_t state;
	logic [MON_W-1:0] mem [DEPTH];
	logic [AW-1:0] wr_addr;
	logic [AW-1:0] trig_addr;
	logic [AW-1:0] rd_base;
	logic [AW-1:0] post_left;
	logic [AW-1:0] pre_len;
	logic [AW:0] rd_cnt;
	logic wr_en;
	logic fifo_in_ready;
	logic fifo_out_valid;
	logic fifo_pop;
	logic rd_push;
	logic rearm;
	logic fifo_rst;
	logic [MON_W-1:0] fifo_out_data;

	assign pre_len = AW'(pre_q) * AW'(DEPTH / 4);
	assign wr_en = state == ela_pkg::ELA_ARMED || state == ela_pkg::ELA_POST;
	assign rd_push = state == ela_pkg::ELA_DONE && rd_cnt != (AW+1)'(DEPTH);
	assign rearm = state == ela_pkg::ELA_DONE && rep && rd_cnt == (AW+1)'(DEPTH)
		&& !fifo_out_valid;

	always_ff @(posedge core_clk) begin
		if (wr_en) begin
			mem[wr_addr] <= mon_data;
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			state <= INIT_EN ? ela_pkg::ELA_ARMED : ela_pkg::ELA_IDLE;
			stage <= '0;
			wr_addr <= '0;
			trig_addr <= '0;
			rd_base <= '0;
			post_left <= '0;
			rd_cnt <= '0;
		end else if (cmd_arm || rearm) begin
			state <= ela_pkg::ELA_ARMED;
			stage <= '0;
			rd_cnt <= '0;
		end else begin
			if (wr_en) begin
				wr_addr <= wr_addr + 1'b1;
			end
			case (state)
				ela_pkg::ELA_ARMED: begin
					if (trig_fire) begin
						state <= ela_pkg::ELA_POST;
						trig_addr <= wr_addr;
						// history is only valid once the ring has wrapped far enough
						rd_base <= wr_addr - pre_len;
						post_left <= AW'(DEPTH - 1) - pre_len;
					end else if (hit_cur) begin
						stage <= stage + 1'b1;
					end
				end
				ela_pkg::ELA_POST: begin
					post_left <= post_left - 1'b1;
					if (post_left == AW'(1)) begin
						state <= ela_pkg::ELA_DONE;
					end
				end
				ela_pkg::ELA_DONE: begin
					if (rd_push && fifo_in_ready) begin
						rd_cnt <= rd_cnt + 1'b1;
					end
				end
				default: begin
					stage <= '0;
				end
			endcase
		end
	end

	ela_fifo #(
		.W(MON_W),
		.D(ela_pkg::FIFO_DEPTH)
	) u_fifo (
		.core_clk(core_clk),
		.sys_rst(fifo_rst),
		.in_valid(rd_push),
		.in_ready(fifo_in_ready),
		.in_data(mem[rd_base + rd_cnt[AW-1:0]]),
		.out_valid(fifo_out_valid),
		.out_ready(fifo_pop),
		.out_data(fifo_out_data)
	);

	assign fifo_pop = frame_end && op == ela_pkg::OP_READ;
	// arm drops words left over from the previous capture, else they would be read again
	assign fifo_rst = sys_rst || cmd_arm;

	always_comb begin
		resp = '0;
		if (op == ela_pkg::OP_STATUS) begin
			resp = FW'({rd_cnt, stage, state});
		end else if (op == ela_pkg::OP_READ) begin
			resp = FW'({fifo_out_valid, fifo_out_data});
		end
	end

	always_ff @(posedge core_clk) begin
		if (sys_rst) begin
			capture_done <= 1'b0;
			capture_armed <= 1'b0;
		end else begin
			capture_done <= state == ela_pkg::ELA_DONE;
			capture_armed <= state == ela_pkg::ELA_ARMED;
		end
	end

	// ****************************************
	// checks
	// ****************************************
	default clocking cb @(posedge core_clk); endclocking
	default disable iff (sys_rst);

	a_last_cond_fires: assert property (
		(state == ela_pkg::ELA_ARMED && trig_fire && !cmd_arm) |=> state == ela_pkg::ELA_POST)
		else $error("last condition did not start post capture");
	a_stage_steps_up: assert property (
		(state == ela_pkg::ELA_ARMED && hit_cur && !trig_fire && !cmd_arm)
		|=> stage == $past(stage) + 2'h1)
		else $error("trigger stage did not advance");
	a_pre_history: assert property (
		(state == ela_pkg::ELA_ARMED && trig_fire && !cmd_arm)
		|=> rd_base + pre_len == $past(wr_addr))
		else $error("read base does not hold the pre-trigger amount");
	a_post_end: assert property (
		(state == ela_pkg::ELA_POST && post_left == AW'(1) && !cmd_arm)
		|=> state == ela_pkg::ELA_DONE ##1 capture_done)
		else $error("capture did not complete after post count");
	a_done_no_write: assert property (
		state == ela_pkg::ELA_DONE |-> !wr_en)
		else $error("sample memory written after completion");
	a_write_steps: assert property (
		(wr_en && !cmd_arm && !rearm) |=> wr_addr == $past(wr_addr) + 1'b1)
		else $error("sample address did not advance");
	a_stim_load: assert property (
		(frame_end && op == ela_pkg::OP_STIM) |=> stim_out == $past(pay[STIM_W-1:0]))
		else $error("stimulus not loaded from frame");
	a_rep_rearm: assert property (
		rearm |=> state == ela_pkg::ELA_ARMED && rd_cnt == '0)
		else $error("repetitive mode did not re-arm");
	a_arm_flush: assert property (
		cmd_arm |=> !fifo_out_valid)
		else $error("readout buffer kept words across an arm");
	a_tdo_release: assert property (
		!sel_s |=> jtag_tdo_oe_n)
		else $error("tdo driven while chain not selected");
	a_and_cond: assert property (
		(state == ela_pkg::ELA_ARMED && !or_sel[stage] && mask[stage] == '0 && stage == ncond_m1
		&& !cmd_arm) |=> state == ela_pkg::ELA_POST)
		else $error("empty AND condition did not fire");

	c_capture: cover property (state == ela_pkg::ELA_POST ##[1:600] state == ela_pkg::ELA_DONE);
	c_three_stage: cover property (state == ela_pkg::ELA_ARMED && stage == 2'h2 && trig_fire);
	c_rearm: cover property (rearm);
	c_read_word: cover property (fifo_pop && fifo_out_valid);
endmodule

// *** bench/ela_host.sv ***
`timescale 1ns/1ps
// ****************************************
// jtag pod model
// ****************************************
module ela_host #(
	parameter int HALF = 100
) (
	// pod pins
	output logic jtag_tck,
	output logic jtag_tdi,
	output logic jtag_sel,
	input wire logic jtag_tdo
);
	logic [47:0] rsp;
	initial begin
		jtag_tck = 1'b0;
		jtag_tdi = 1'b0;
		jtag_sel = 1'b0;
		rsp = '0;
	end
	// one frame, lsb first; rsp holds the answer to the frame before
	task automatic frame(input logic [3:0] op, input logic [1:0] idx, input logic [39:0] pay);
		logic [47:0] w;
		w = {op, 2'h0, idx, pay};
		#7;
		jtag_sel = 1'b1;
		#(2 * HALF);
		for (int i = 0; i < 48; i++) begin
			jtag_tdi = w[i];
			#HALF;
			rsp[i] = jtag_tdo;
			jtag_tck = 1'b1;
			#HALF;
			jtag_tck = 1'b0;
		end
		#HALF;
		jtag_sel = 1'b0;
		// released line: do not leave the last bit standing
		jtag_tdi = ~jtag_tdi;
		#(3 * HALF);
	endtask
endmodule

// *** bench/tb_embedded_logic_analyzer.sv ***
`timescale 1ns/1ps
// ****************************************
// bench top
// ****************************************
module tb_embedded_logic_analyzer;
	localparam int DEPTH = 512;
	logic core_clk = 1'b0;
	logic sys_rst = 1'b1;
	logic [7:0] mon_data;
	logic [7:0] trig_in;
	logic [7:0] noise = 8'h00;
	logic [7:0] noise_m = 8'h00;
	logic [7:0] trig_ctl = 8'h00;
	logic [31:0] rs = 32'h0000489B;
	logic [7:0] stim_out;
	logic [7:0] stim_v;
	logic jtag_tck, jtag_tdi, jtag_sel, jtag_tdo, jtag_tdo_oe_n, tdo_pin;
	logic capture_done, capture_armed, init_done, init_armed;
	logic [7:0] hist[$];
	int err_count = 0;
	int compares = 0;
	int cyc = 0;
	int t_trig;
	int n;

	always #12.5 core_clk = ~core_clk;
	assign mon_data = rs[7:0];
	assign trig_in = (noise & noise_m) | (trig_ctl & ~noise_m);
	// pulled up while released
	assign tdo_pin = jtag_tdo_oe_n ? 1'b1 : jtag_tdo;

	// ****************************************
	// designs and host
	// ****************************************
	ela_top #(.DEPTH(DEPTH)) u_dut (.core_clk(core_clk), .sys_rst(sys_rst),
		.mon_data(mon_data), .trig_in(trig_in), .stim_out(stim_out),
		.jtag_tck(jtag_tck), .jtag_tdi(jtag_tdi), .jtag_sel(jtag_sel),
		.jtag_tdo(jtag_tdo), .jtag_tdo_oe_n(jtag_tdo_oe_n),
		.capture_done(capture_done), .capture_armed(capture_armed));
	ela_top #(.DEPTH(DEPTH), .INIT_EN(1'b1), .INIT_MASK(8'h01), .INIT_MODE0(8'h01)) u_dut_init (
		.core_clk(core_clk), .sys_rst(sys_rst), .mon_data(mon_data),
		.trig_in(trig_in), .stim_out(), .jtag_tck(jtag_tck), .jtag_tdi(jtag_tdi),
		.jtag_sel(1'b0), .jtag_tdo(), .jtag_tdo_oe_n(),
		.capture_done(init_done), .capture_armed(init_armed));
	ela_host u_host (.jtag_tck(jtag_tck), .jtag_tdi(jtag_tdi), .jtag_sel(jtag_sel),
		.jtag_tdo(tdo_pin));

	// ****************************************
	// model, stimulus and reporting
	// ****************************************
	function automatic logic [31:0] xs(input logic [31:0] v);
		logic [31:0] r;
		r = v ^ (v << 13);
		r = r ^ (r >> 17);
		return r ^ (r << 5);
	endfunction

	task automatic check(input string nm, input logic [47:0] seen, input logic [47:0] exp);
		compares++;
		if (seen !== exp) begin
			err_count++;
			$display("MISMATCH %s expected %h seen %h", nm, exp, seen);
		end
	endtask

	task automatic give_verdict();
		$display("compares %0d err_count %0d", compares, err_count);
		if (err_count == 0 && compares > 0) begin
			$display("Test passed");
		end else begin
			$display("Test failed");
		end
		$finish;
	endtask

	task automatic cond(input logic [1:0] i, input logic [7:0] m, m0, m1, input logic orr);
		u_host.frame(ela_pkg::OP_MASK, i, {32'h0, m});
		u_host.frame(ela_pkg::OP_MODE0, i, {32'h0, m0});
		u_host.frame(ela_pkg::OP_MODE1, i, {32'h0, m1});
		u_host.frame(ela_pkg::OP_COMB, i, {39'h0, orr});
	endtask

	task automatic wait_done();
		n = 0;
		while (capture_done !== 1'b1 && n < 1000) begin
			@(negedge core_clk);
			n++;
		end
	endtask

	// every sample the design could take, one per clock
	always @(posedge core_clk) begin
		hist.push_back(mon_data);
		cyc++;
		if (cyc == 30000) begin
			err_count++;
			give_verdict();
		end
	end

	always @(negedge core_clk) begin
		rs = xs(rs);
		noise = rs[15:8];
	end

	// ****************************************
	// scenarios
	// ****************************************
	initial begin
		repeat (4) @(negedge core_clk);
		check("reset_outs", {stim_out, jtag_tdo, jtag_tdo_oe_n, capture_done, capture_armed},
			12'h004);
		@(negedge core_clk);
		sys_rst = 1'b0;
		repeat (3) @(negedge core_clk);
		check("init_armed", init_armed, 1'b1);
		stim_v = rs[23:16];
		u_host.frame(ela_pkg::OP_STIM, 2'h0, {32'h0, stim_v});
		check("stim", stim_out, stim_v);
		check("oe_idle", jtag_tdo_oe_n, 1'b1);
		// single rising-edge condition, one quarter of history
		@(negedge core_clk);
		noise_m = 8'hFE;
		cond(2'h0, 8'h01, 8'h00, 8'h01, 1'b0);
		u_host.frame(ela_pkg::OP_CTRL, 2'h0, 40'h24);
		@(negedge core_clk);
		check("armed", capture_armed, 1'b1);
		repeat (600) @(negedge core_clk);
		check("masked_noise", capture_armed, 1'b1);
		trig_ctl = 8'h01;
		t_trig = hist.size();
		wait_done();
		check("done_lat", n >= 380 && n <= 392, 1'b1);
		u_host.frame(ela_pkg::OP_STATUS, 2'h0, 40'h0);
		u_host.frame(ela_pkg::OP_READ, 2'h0, 40'h0);
		check("state", u_host.rsp[1:0], 2'h2);
		for (int k = 0; k < 6; k++) begin
			u_host.frame(ela_pkg::OP_READ, 2'h0, 40'h0);
			check("sample", u_host.rsp[8:0], {1'b1, hist[t_trig - DEPTH / 4 + k]});
		end
		check("init_done", init_done, 1'b1);
		// three conditions: level high, OR of falls, AND of levels
		@(negedge core_clk);
		noise_m = 8'hC0;
		trig_ctl = 8'h1C;
		cond(2'h0, 8'h02, 8'h02, 8'h00, 1'b0);
		cond(2'h1, 8'h0C, 8'h0C, 8'h0C, 1'b1);
		cond(2'h2, 8'h30, 8'h20, 8'h00, 1'b0);
		// three conditions, no history, repetitive
		u_host.frame(ela_pkg::OP_CTRL, 2'h0, 40'h32);
		@(negedge core_clk);
		trig_ctl = 8'h14;
		repeat (8) @(negedge core_clk);
		trig_ctl = 8'h16;
		repeat (8) @(negedge core_clk);
		trig_ctl = 8'h26;
		repeat (8) @(negedge core_clk);
		check("order", capture_armed, 1'b1);
		trig_ctl = 8'h22;
		// stage two is reached at the next edge and fires at the one after
		t_trig = hist.size() + 1;
		repeat (8) @(negedge core_clk);
		check("fired", capture_armed, 1'b0);
		wait_done();
		check("done2", capture_done, 1'b1);
		check("stim_hold", stim_out, stim_v);
		u_host.frame(ela_pkg::OP_STATUS, 2'h0, 40'h0);
		u_host.frame(ela_pkg::OP_READ, 2'h0, 40'h0);
		check("state2", u_host.rsp[1:0], 2'h2);
		check("buffered", u_host.rsp[13:4], 10'(ela_pkg::FIFO_DEPTH));
		for (int k = 0; k < 4; k++) begin
			u_host.frame(ela_pkg::OP_READ, 2'h0, 40'h0);
			check("sample2", u_host.rsp[8:0], {1'b1, hist[t_trig + k]});
		end
		// repetitive mode must wait for the whole capture to be read out
		check("rep_hold", {capture_done, capture_armed}, 2'h2);
		give_verdict();
	end
endmodule
